// File: pkg/cmsb_pkg.sv
package cmsb_pkg;

  // Clock and bus timing.
  localparam int SYS_CLK_MHZ = 100;
  localparam int T_STATE_NS = 200;
  localparam int T_STATE_CYCLES = (T_STATE_NS * SYS_CLK_MHZ + 999) / 1000;

  // Reset values.
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Opcode field positions.
  localparam int FLD_DST_HI = 5;
  localparam int FLD_DST_LO = 3;
  localparam int FLD_SRC_HI = 2;
  localparam int FLD_SRC_LO = 0;
  localparam int FLD_PAIR_HI = 5;
  localparam int FLD_PAIR_LO = 4;
  localparam int FLD_GRP_HI = 7;
  localparam int FLD_GRP_LO = 6;

  // Opcode groups and patterns.
  localparam logic [1:0] GRP_LOW = 2'h0;
  localparam logic [1:0] GRP_COPY = 2'h1;
  localparam logic [1:0] GRP_HIGH = 2'h3;
  localparam logic [7:0] OP_HALT = 8'h76;
  localparam logic [7:0] OP_PAIR_SWAP = 8'hEB;
  localparam logic [7:0] OP_STACK_TOP_SWAP = 8'hE3;
  localparam logic [7:0] OP_PAIR_TO_PC = 8'hE9;
  localparam logic [7:0] OP_BRANCH = 8'hC3;
  localparam logic [7:0] OP_CALL = 8'hCD;
  localparam logic [2:0] PAT_IMM_BYTE = 3'h6;
  localparam logic [3:0] PAT_PAIR_IMM = 4'h1;
  localparam logic [3:0] PAT_PUSH = 4'h5;
  localparam logic [3:0] PAT_POP = 4'h1;
  localparam logic [2:0] PAT_COND_BRANCH = 3'h2;
  localparam logic [2:0] PAT_COND_CALL = 3'h4;

  // Register codes; slot 6 never names a register, so the flag byte lives there.
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_F = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam logic [1:0] PAIR_SP = 2'h3;
  localparam logic [1:0] PAIR_PSW = 2'h3;

  // Flag byte bit positions.
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_P = 2;
  localparam int FLAG_C = 0;

  // Condition field: upper two bits pick the flag, low bit the sense.
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_CARRY = 2'h1;
  localparam logic [1:0] CC_PARITY = 2'h2;
  localparam logic [1:0] CC_SIGN = 2'h3;

  // Instruction lengths in T-states.
  localparam logic [4:0] CYC_COPY = 5'h04;
  localparam logic [4:0] CYC_MEM_MOVE = 5'h07;
  localparam logic [4:0] CYC_IMM_REG = 5'h07;
  localparam logic [4:0] CYC_IMM_MEM = 5'h0A;
  localparam logic [4:0] CYC_PAIR_IMM = 5'h0A;
  localparam logic [4:0] CYC_PAIR_SWAP = 5'h04;
  localparam logic [4:0] CYC_PUSH = 5'h0C;
  localparam logic [4:0] CYC_POP = 5'h0A;
  localparam logic [4:0] CYC_STACK_TOP_SWAP = 5'h10;
  localparam logic [4:0] CYC_PAIR_TO_PC = 5'h06;
  localparam logic [4:0] CYC_BRANCH = 5'h0A;
  localparam logic [4:0] CYC_BRANCH_SKIP = 5'h07;
  localparam logic [4:0] CYC_CALL = 5'h12;
  localparam logic [4:0] CYC_CALL_SKIP = 5'h09;
  localparam logic [4:0] CYC_OTHER = 5'h04;
  localparam logic [4:0] T_PER_XFER = 5'h03;

  localparam logic IO_MEM_MEMORY = 1'b0;

  typedef enum logic [2:0] {ST_T1, ST_T2, ST_TW, ST_T3, ST_TX, ST_HOLD} cmsb_state_type;

  typedef enum logic [3:0] {
    CL_COPY, CL_STORE_M, CL_LOAD_M, CL_IMM_REG, CL_IMM_MEM, CL_PAIR_IMM, CL_PAIR_SWAP,
    CL_PUSH, CL_POP, CL_STACK_SWAP, CL_PAIR_TO_PC, CL_BRANCH, CL_COND_BRANCH, CL_CALL,
    CL_COND_CALL, CL_OTHER
  } cmsb_class_type;

endpackage

// File: core/cmsb_tick.sv
`timescale 1ns/1ps
module cmsb_tick #(
  parameter int DIV = cmsb_pkg::T_STATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } cmsb_tick_state_type;

  cmsb_tick_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == CW'(DIV - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule // cmsb_tick

// File: core/cmsb_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Register copy 01DDDSSS, four cycles.
// - Register to memory at H/L, seven cycles.
// - Memory at H/L to register, seven cycles.
// - Pair immediate load 00PP0001, ten cycles.
// - Swap D/E with H/L, four cycles.
// - Push pair 11PP0101, twelve cycles.
// - Push accumulator and flags, twelve cycles.
// - Pop pair 11PP0001, ten cycles.
// - Pop accumulator and flags, ten cycles.
// - Swap stack top with H/L, sixteen cycles.
// - H/L into program counter, six cycles.
// - Writes wait on READY like reads.
// - Bus hold also floats the I/O-memory indicator.
module cmsb_core #(
  parameter int T_STATE_DIV = cmsb_pkg::T_STATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ready,
  input wire logic hold_req,
  input wire logic [7:0] bus_rdata,
  output logic [15:0] bus_addr,
  output logic bus_addr_oe,
  output logic [7:0] bus_wdata,
  output logic bus_data_oe,
  output logic bus_ale,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic io_mem,
  output logic io_mem_oe,
  output logic bus_grant_ack,
  output logic [15:0] pc_value,
  output logic [15:0] sp_value,
  output logic instr_done,
  output logic unsupported_op
);

  typedef struct packed {
    cmsb_pkg::cmsb_state_type state;
    logic fetch;
    cmsb_pkg::cmsb_class_type cls;
    logic [7:0] op;
    logic taken;
    logic [2:0] step;
    logic [2:0] nxfer;
    logic [4:0] icnt;
    logic [7:0][7:0] regs;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] w;
    logic [7:0] z;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic pcinc;
    logic done;
    logic unsup;
  } cmsb_core_state_type;

  typedef struct packed {
    logic wr;
    logic pcinc;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cmsb_xfer_type;

  cmsb_core_state_type s_q, s_d;
  logic tick;

  cmsb_tick #(
    .DIV(T_STATE_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  function automatic logic [2:0] dst_of(input logic [7:0] op);
    return op[cmsb_pkg::FLD_DST_HI:cmsb_pkg::FLD_DST_LO];
  endfunction

  function automatic logic [2:0] src_of(input logic [7:0] op);
    return op[cmsb_pkg::FLD_SRC_HI:cmsb_pkg::FLD_SRC_LO];
  endfunction

  function automatic logic [1:0] pair_of(input logic [7:0] op);
    return op[cmsb_pkg::FLD_PAIR_HI:cmsb_pkg::FLD_PAIR_LO];
  endfunction

  // Pair code 3 means the accumulator and flags on the stack, the stack pointer elsewhere.
  function automatic logic [2:0] pair_hi(input logic [1:0] pp);
    return (pp == cmsb_pkg::PAIR_PSW) ? cmsb_pkg::REG_A : {pp, 1'b0};
  endfunction

  function automatic logic [2:0] pair_lo(input logic [1:0] pp);
    return (pp == cmsb_pkg::PAIR_PSW) ? cmsb_pkg::REG_F : {pp, 1'b1};
  endfunction

  function automatic cmsb_pkg::cmsb_class_type op_class(input logic [7:0] op);
    logic [1:0] grp;
    grp = op[cmsb_pkg::FLD_GRP_HI:cmsb_pkg::FLD_GRP_LO];
    if (op == cmsb_pkg::OP_HALT) begin
      return cmsb_pkg::CL_OTHER;
    end else if (grp == cmsb_pkg::GRP_COPY) begin
      if (dst_of(op) == cmsb_pkg::REG_MEM) begin
        return cmsb_pkg::CL_STORE_M;
      end else if (src_of(op) == cmsb_pkg::REG_MEM) begin
        return cmsb_pkg::CL_LOAD_M;
      end
      return cmsb_pkg::CL_COPY;
    end else if (grp == cmsb_pkg::GRP_LOW) begin
      if (src_of(op) == cmsb_pkg::PAT_IMM_BYTE) begin
        return (dst_of(op) == cmsb_pkg::REG_MEM) ? cmsb_pkg::CL_IMM_MEM : cmsb_pkg::CL_IMM_REG;
      end else if (op[3:0] == cmsb_pkg::PAT_PAIR_IMM) begin
        return cmsb_pkg::CL_PAIR_IMM;
      end
      return cmsb_pkg::CL_OTHER;
    end else if (grp == cmsb_pkg::GRP_HIGH) begin
      case (op)
        cmsb_pkg::OP_PAIR_SWAP: return cmsb_pkg::CL_PAIR_SWAP;
        cmsb_pkg::OP_STACK_TOP_SWAP: return cmsb_pkg::CL_STACK_SWAP;
        cmsb_pkg::OP_PAIR_TO_PC: return cmsb_pkg::CL_PAIR_TO_PC;
        cmsb_pkg::OP_BRANCH: return cmsb_pkg::CL_BRANCH;
        cmsb_pkg::OP_CALL: return cmsb_pkg::CL_CALL;
        default: begin
          if (op[3:0] == cmsb_pkg::PAT_PUSH) begin
            return cmsb_pkg::CL_PUSH;
          end else if (op[3:0] == cmsb_pkg::PAT_POP) begin
            return cmsb_pkg::CL_POP;
          end else if (src_of(op) == cmsb_pkg::PAT_COND_BRANCH) begin
            return cmsb_pkg::CL_COND_BRANCH;
          end else if (src_of(op) == cmsb_pkg::PAT_COND_CALL) begin
            return cmsb_pkg::CL_COND_CALL;
          end
          return cmsb_pkg::CL_OTHER;
        end
      endcase
    end
    return cmsb_pkg::CL_OTHER;
  endfunction

  // The low bit of the field picks the true sense of the chosen flag.
  function automatic logic cond_true(input logic [2:0] cc, input logic [7:0] f);
    logic bit_v;
    case (cc[2:1])
      cmsb_pkg::CC_ZERO: bit_v = f[cmsb_pkg::FLAG_Z];
      cmsb_pkg::CC_CARRY: bit_v = f[cmsb_pkg::FLAG_C];
      cmsb_pkg::CC_PARITY: bit_v = f[cmsb_pkg::FLAG_P];
      default: bit_v = f[cmsb_pkg::FLAG_S];
    endcase
    return bit_v == cc[0];
  endfunction

  function automatic logic [2:0] xfer_count(input cmsb_pkg::cmsb_class_type c, input logic tk);
    case (c)
      cmsb_pkg::CL_STORE_M, cmsb_pkg::CL_LOAD_M, cmsb_pkg::CL_IMM_REG: return 3'h1;
      cmsb_pkg::CL_IMM_MEM, cmsb_pkg::CL_PAIR_IMM, cmsb_pkg::CL_PUSH: return 3'h2;
      cmsb_pkg::CL_POP, cmsb_pkg::CL_BRANCH: return 3'h2;
      cmsb_pkg::CL_STACK_SWAP, cmsb_pkg::CL_CALL: return 3'h4;
      cmsb_pkg::CL_COND_BRANCH: return tk ? 3'h2 : 3'h1;
      cmsb_pkg::CL_COND_CALL: return tk ? 3'h4 : 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [4:0] op_cycles(input cmsb_pkg::cmsb_class_type c, input logic tk);
    case (c)
      cmsb_pkg::CL_COPY: return cmsb_pkg::CYC_COPY;
      cmsb_pkg::CL_STORE_M, cmsb_pkg::CL_LOAD_M: return cmsb_pkg::CYC_MEM_MOVE;
      cmsb_pkg::CL_IMM_REG: return cmsb_pkg::CYC_IMM_REG;
      cmsb_pkg::CL_IMM_MEM: return cmsb_pkg::CYC_IMM_MEM;
      cmsb_pkg::CL_PAIR_IMM: return cmsb_pkg::CYC_PAIR_IMM;
      cmsb_pkg::CL_PAIR_SWAP: return cmsb_pkg::CYC_PAIR_SWAP;
      cmsb_pkg::CL_PUSH: return cmsb_pkg::CYC_PUSH;
      cmsb_pkg::CL_POP: return cmsb_pkg::CYC_POP;
      cmsb_pkg::CL_STACK_SWAP: return cmsb_pkg::CYC_STACK_TOP_SWAP;
      cmsb_pkg::CL_PAIR_TO_PC: return cmsb_pkg::CYC_PAIR_TO_PC;
      cmsb_pkg::CL_BRANCH: return cmsb_pkg::CYC_BRANCH;
      cmsb_pkg::CL_COND_BRANCH: return tk ? cmsb_pkg::CYC_BRANCH : cmsb_pkg::CYC_BRANCH_SKIP;
      cmsb_pkg::CL_CALL: return cmsb_pkg::CYC_CALL;
      cmsb_pkg::CL_COND_CALL: return tk ? cmsb_pkg::CYC_CALL : cmsb_pkg::CYC_CALL_SKIP;
      default: return cmsb_pkg::CYC_OTHER;
    endcase
  endfunction

  // Address, direction and write data of the bus transfer numbered t.step.
  function automatic cmsb_xfer_type xfer_plan(input cmsb_core_state_type t);
    cmsb_xfer_type p;
    logic [15:0] hl;
    logic [1:0] pp;
    hl = {t.regs[cmsb_pkg::REG_H], t.regs[cmsb_pkg::REG_L]};
    pp = pair_of(t.op);
    p = '{wr: 1'b0, pcinc: 1'b1, addr: t.pc, wdata: 8'h00};
    case (t.cls)
      cmsb_pkg::CL_STORE_M: p = '{1'b1, 1'b0, hl, t.regs[src_of(t.op)]};
      cmsb_pkg::CL_LOAD_M: p = '{1'b0, 1'b0, hl, 8'h00};
      cmsb_pkg::CL_IMM_MEM: begin
        if (t.step != 3'h0) begin
          p = '{1'b1, 1'b0, hl, t.z};
        end
      end
      cmsb_pkg::CL_PUSH: begin
        if (t.step == 3'h0) begin
          p = '{1'b1, 1'b0, t.sp - 16'h0001, t.regs[pair_hi(pp)]};
        end else begin
          p = '{1'b1, 1'b0, t.sp - 16'h0002, t.regs[pair_lo(pp)]};
        end
      end
      cmsb_pkg::CL_POP: p = '{1'b0, 1'b0, t.sp + 16'(t.step), 8'h00};
      cmsb_pkg::CL_STACK_SWAP: begin
        case (t.step)
          3'h0: p = '{1'b0, 1'b0, t.sp, 8'h00};
          3'h1: p = '{1'b0, 1'b0, t.sp + 16'h0001, 8'h00};
          3'h2: p = '{1'b1, 1'b0, t.sp + 16'h0001, t.regs[cmsb_pkg::REG_H]};
          default: p = '{1'b1, 1'b0, t.sp, t.regs[cmsb_pkg::REG_L]};
        endcase
      end
      cmsb_pkg::CL_CALL, cmsb_pkg::CL_COND_CALL: begin
        if (t.step == 3'h2) begin
          p = '{1'b1, 1'b0, t.sp - 16'h0001, t.pc[15:8]};
        end else if (t.step == 3'h3) begin
          p = '{1'b1, 1'b0, t.sp - 16'h0002, t.pc[7:0]};
        end
      end
      default: p = '{1'b0, 1'b1, t.pc, 8'h00};
    endcase
    return p;
  endfunction

  always_comb begin
    logic do_retire;
    logic do_begin;
    logic [2:0] nstep;
    logic [1:0] pp;
    cmsb_pkg::cmsb_class_type c;
    cmsb_xfer_type plan;
    do_retire = 1'b0;
    do_begin = 1'b0;
    nstep = s_q.step + 3'h1;
    pp = pair_of(s_q.op);
    c = op_class(bus_rdata);
    plan = '0;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.unsup = 1'b0;
    if (tick) begin
      case (s_q.state)
        cmsb_pkg::ST_T1: s_d.state = cmsb_pkg::ST_T2;
        // Writes and reads stretch alike; READY is looked at once per T-state.
        cmsb_pkg::ST_T2, cmsb_pkg::ST_TW: begin
          s_d.state = ready ? cmsb_pkg::ST_T3 : cmsb_pkg::ST_TW;
        end
        cmsb_pkg::ST_T3: begin
          if (s_q.fetch) begin
            s_d.op = bus_rdata;
            s_d.cls = c;
            s_d.taken = 1'b1;
            if (c == cmsb_pkg::CL_COND_BRANCH || c == cmsb_pkg::CL_COND_CALL) begin
              s_d.taken = cond_true(dst_of(bus_rdata), s_q.regs[cmsb_pkg::REG_F]);
            end
            s_d.pc = s_q.pc + 16'h0001;
            s_d.nxfer = xfer_count(c, s_d.taken);
            s_d.icnt = op_cycles(c, s_d.taken) - cmsb_pkg::T_PER_XFER
                       - 5'(s_d.nxfer) * cmsb_pkg::T_PER_XFER;
            s_d.step = 3'h0;
            s_d.fetch = 1'b0;
            s_d.state = cmsb_pkg::ST_TX;
          end else begin
            if (!s_q.wr) begin
              if (s_q.cls == cmsb_pkg::CL_IMM_REG || s_q.cls == cmsb_pkg::CL_LOAD_M) begin
                s_d.regs[dst_of(s_q.op)] = bus_rdata;
              end else if (s_q.step == 3'h0) begin
                s_d.z = bus_rdata;
              end else begin
                s_d.w = bus_rdata;
              end
            end
            if (s_q.pcinc) begin
              s_d.pc = s_q.pc + 16'h0001;
            end
            s_d.step = nstep;
            do_retire = (nstep == s_q.nxfer);
            do_begin = (nstep != s_q.nxfer);
          end
        end
        cmsb_pkg::ST_TX: begin
          if (s_q.icnt == 5'h01) begin
            do_retire = (s_q.nxfer == 3'h0);
            do_begin = (s_q.nxfer != 3'h0);
          end else begin
            s_d.icnt = s_q.icnt - 5'h01;
          end
        end
        cmsb_pkg::ST_HOLD: begin
          if (!hold_req) begin
            s_d.state = cmsb_pkg::ST_T1;
          end
        end
        default: s_d.state = cmsb_pkg::ST_T1;
      endcase
    end
    if (do_retire) begin
      case (s_q.cls)
        cmsb_pkg::CL_COPY: s_d.regs[dst_of(s_q.op)] = s_q.regs[src_of(s_q.op)];
        cmsb_pkg::CL_PAIR_SWAP: begin
          s_d.regs[cmsb_pkg::REG_D] = s_q.regs[cmsb_pkg::REG_H];
          s_d.regs[cmsb_pkg::REG_E] = s_q.regs[cmsb_pkg::REG_L];
          s_d.regs[cmsb_pkg::REG_H] = s_q.regs[cmsb_pkg::REG_D];
          s_d.regs[cmsb_pkg::REG_L] = s_q.regs[cmsb_pkg::REG_E];
        end
        cmsb_pkg::CL_PAIR_IMM: begin
          if (pp == cmsb_pkg::PAIR_SP) begin
            s_d.sp = {s_d.w, s_d.z};
          end else begin
            s_d.regs[pair_hi(pp)] = s_d.w;
            s_d.regs[pair_lo(pp)] = s_d.z;
          end
        end
        cmsb_pkg::CL_PUSH: s_d.sp = s_q.sp - 16'h0002;
        cmsb_pkg::CL_POP: begin
          s_d.regs[pair_hi(pp)] = s_d.w;
          s_d.regs[pair_lo(pp)] = s_d.z;
          s_d.sp = s_q.sp + 16'h0002;
        end
        cmsb_pkg::CL_STACK_SWAP: begin
          s_d.regs[cmsb_pkg::REG_H] = s_d.w;
          s_d.regs[cmsb_pkg::REG_L] = s_d.z;
        end
        cmsb_pkg::CL_PAIR_TO_PC: begin
          s_d.pc = {s_q.regs[cmsb_pkg::REG_H], s_q.regs[cmsb_pkg::REG_L]};
        end
        cmsb_pkg::CL_BRANCH, cmsb_pkg::CL_COND_BRANCH, cmsb_pkg::CL_CALL,
        cmsb_pkg::CL_COND_CALL: begin
          if (s_q.taken) begin
            s_d.pc = {s_d.w, s_d.z};
            if (s_q.cls == cmsb_pkg::CL_CALL || s_q.cls == cmsb_pkg::CL_COND_CALL) begin
              s_d.sp = s_q.sp - 16'h0002;
            end
          end else begin
            // Only the low address byte was read; step over the high one.
            s_d.pc = s_d.pc + 16'h0001;
          end
        end
        cmsb_pkg::CL_OTHER: s_d.unsup = 1'b1;
        default: s_d.unsup = 1'b0;
      endcase
      s_d.done = 1'b1;
      s_d.fetch = 1'b1;
      s_d.wr = 1'b0;
      s_d.pcinc = 1'b1;
      s_d.addr = s_d.pc;
      s_d.state = hold_req ? cmsb_pkg::ST_HOLD : cmsb_pkg::ST_T1;
    end
    if (do_begin) begin
      plan = xfer_plan(s_d);
      s_d.wr = plan.wr;
      s_d.pcinc = plan.pcinc;
      s_d.addr = plan.addr;
      s_d.wdata = plan.wdata;
      s_d.state = hold_req ? cmsb_pkg::ST_HOLD : cmsb_pkg::ST_T1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= cmsb_pkg::ST_T1;
      s_q.fetch <= 1'b1;
      s_q.cls <= cmsb_pkg::CL_OTHER;
      s_q.pcinc <= 1'b1;
      s_q.pc <= cmsb_pkg::PC_RESET;
      s_q.sp <= cmsb_pkg::SP_RESET;
      s_q.addr <= cmsb_pkg::PC_RESET;
      s_q.regs <= {8{cmsb_pkg::REG_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  logic strobe_phase;
  logic in_hold;
  assign strobe_phase = (s_q.state == cmsb_pkg::ST_T2) || (s_q.state == cmsb_pkg::ST_TW)
                        || (s_q.state == cmsb_pkg::ST_T3);
  assign in_hold = (s_q.state == cmsb_pkg::ST_HOLD);

  assign bus_addr = s_q.addr;
  assign bus_addr_oe = !in_hold;
  assign bus_wdata = s_q.wdata;
  assign bus_data_oe = strobe_phase && s_q.wr;
  assign bus_ale = (s_q.state == cmsb_pkg::ST_T1);
  assign bus_rd_n = !(strobe_phase && !s_q.wr);
  assign bus_wr_n = !(strobe_phase && s_q.wr);
  assign io_mem = cmsb_pkg::IO_MEM_MEMORY;
  assign io_mem_oe = !in_hold;
  assign bus_grant_ack = in_hold;
  assign pc_value = s_q.pc;
  assign sp_value = s_q.sp;
  assign instr_done = s_q.done;
  assign unsupported_op = s_q.unsup;
endmodule // cmsb_core

// File: sim/cmsb_core_assertions.sv
`timescale 1ns/1ps
module cmsb_core_assertions #(
  parameter int T_STATE_DIV = cmsb_pkg::T_STATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ready,
  input wire logic hold_req,
  input wire logic [15:0] bus_addr,
  input wire logic bus_addr_oe,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_data_oe,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic io_mem_oe,
  input wire logic bus_grant_ack,
  input wire logic instr_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // No instruction is shorter than four states, so a short gap means a lost state.
  int gap_q;
  always_ff @(posedge sys_clk) begin
    gap_q <= (rst || instr_done) ? 0 : gap_q + 1;
  end
  AST_HOLD_FLOAT: assert property (bus_grant_ack |-> !io_mem_oe && !bus_data_oe)
    else $error("indicator or data driven in hold");
  AST_HOLD_DRIVE: assert property (bus_addr_oe == !bus_grant_ack)
    else $error("address enable disagrees with grant");
  AST_GRANT_CAUSE: assert property ($rose(bus_grant_ack) |-> $past(hold_req))
    else $error("grant without request");
  AST_WAIT_WR: assert property (!bus_wr_n && !ready |=> !bus_wr_n)
    else $error("write ended while not ready");
  AST_WAIT_RD: assert property (!bus_rd_n && !ready |=> !bus_rd_n)
    else $error("read ended while not ready");
  AST_WR_HOLD: assert property (!bus_wr_n && !ready
    |=> $stable(bus_addr) && $stable(bus_wdata))
    else $error("write changed during wait");
  AST_WR_OE: assert property (bus_data_oe == !bus_wr_n)
    else $error("data enable and write strobe differ");
  AST_MIN_LEN: assert property (instr_done |-> gap_q >= 4 * T_STATE_DIV - 1)
    else $error("instruction shorter than four states");
  cover property (!bus_wr_n && !ready);
  cover property (!bus_rd_n && !ready);
  cover property ($rose(bus_grant_ack));
endmodule // cmsb_core_assertions

// File: sim/cmsb_mem_model.sv
`timescale 1ns/1ps
module cmsb_mem_model (
  input wire logic sys_clk,
  input wire logic [1:0] wait_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_ale,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  output logic [7:0] bus_rdata,
  output logic ready
);
  logic [7:0] m [0:65535];
  logic [23:0] log_q [$];
  logic [7:0] last_q = 8'h00;
  logic [2:0] wcnt_q = 3'h0;
  logic wr_q = 1'b1;
  // Ready only moves just after an edge, so it is steady wherever the core samples it.
  assign ready = wcnt_q == 3'h0;
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign bus_rdata = bus_rd_n ? ~last_q : m[bus_addr];
  always @(posedge sys_clk) begin
    wr_q <= bus_wr_n;
    if (bus_ale) wcnt_q <= {wait_n, 1'b1};
    else if (!bus_rd_n || !bus_wr_n) wcnt_q <= wcnt_q - {2'h0, wcnt_q != 3'h0};
    if (!bus_rd_n) last_q <= m[bus_addr];
    if (!bus_wr_n) m[bus_addr] <= bus_wdata;
    if (!bus_wr_n && wr_q) log_q.push_back({bus_addr, bus_wdata});
  end
endmodule // cmsb_mem_model

// File: sim/cmsb_core_tb.sv
`timescale 1ns/1ps
module cmsb_core_tb;
  localparam int DIV = 2;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hold_req = 1'b0;
  logic [1:0] wait_n = 2'h0;
  logic ready, addr_oe, data_oe, ale, rd_n, wr_n, io_mem, io_oe, grant, done, unsup;
  logic [7:0] rdata, wdata, pm [0:65535], img [0:65535], r [0:7];
  logic [15:0] addr, pc_v, sp_v, pc, sp, end_pc;
  logic [23:0] wq [$];
  int seed = 82;
  int pa, n_fail, checks;
  int fb [4] = '{6, 0, 2, 7};
  int fx [11] = '{8'hEB, 8'hEB, 8'hC5, 8'hD5, 8'hE5, 8'hF5, 8'hE3, 8'hF1, 8'hE1, 8'hD1, 8'hC1};
  always #5 sys_clk = ~sys_clk;
  cmsb_core #(.T_STATE_DIV(DIV)) dut (.sys_clk(sys_clk), .rst(rst), .ready(ready),
    .hold_req(hold_req), .bus_rdata(rdata), .bus_addr(addr), .bus_addr_oe(addr_oe),
    .bus_wdata(wdata), .bus_data_oe(data_oe), .bus_ale(ale), .bus_rd_n(rd_n),
    .bus_wr_n(wr_n), .io_mem(io_mem), .io_mem_oe(io_oe), .bus_grant_ack(grant),
    .pc_value(pc_v), .sp_value(sp_v), .instr_done(done), .unsupported_op(unsup));
  cmsb_mem_model mem (.sys_clk(sys_clk), .wait_n(wait_n), .bus_addr(addr), .bus_wdata(wdata),
    .bus_ale(ale), .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_rdata(rdata), .ready(ready));
  task automatic final_report();
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [23:0] g, input logic [23:0] x, input string s);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, g, x);
    end
  endtask
  function automatic int hx(input logic [7:0] o);
    return o[5:4] == 2'h3 ? 7 : 2 * o[5:4];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    pm[a] = d;
    wq.push_back({a, d});
  endtask
  task automatic e(input int b, input int n = 1);
    for (int i = 0; i < n; i++) begin
      img[pa] = 8'(b >> (8 * i));
      pa++;
    end
  endtask
  task automatic step(output int c, output logic u);
    logic [7:0] o, lo, hi;
    logic [15:0] hl, t;
    logic tk;
    o = pm[pc];
    pc++;
    lo = pm[pc];
    hi = pm[pc + 16'd1];
    hl = {r[4], r[5]};
    c = 4;
    u = 1'b0;
    if (o[7:6] == 2'h1 && o != 8'h76) begin
      c = (o[5:3] == 3'h6 || o[2:0] == 3'h6) ? 7 : 4;
      if (o[5:3] == 3'h6) wr(hl, r[o[2:0]]);
      else r[o[5:3]] = (o[2:0] == 3'h6) ? pm[hl] : r[o[2:0]];
    end else if (o[7:6] == 2'h0 && o[2:0] == 3'h6) begin
      c = (o[5:3] == 3'h6) ? 10 : 7;
      pc++;
      if (o[5:3] == 3'h6) wr(hl, lo);
      else r[o[5:3]] = lo;
    end else if (o[7:6] == 2'h0 && o[3:0] == 4'h1) begin
      c = 10;
      pc += 16'd2;
      if (o[5:4] == 2'h3) sp = {hi, lo};
      else {r[hx(o)], r[hx(o) ^ 1]} = {hi, lo};
    end else if (o == 8'hEB) begin
      t = {r[2], r[3]};
      {r[2], r[3]} = hl;
      {r[4], r[5]} = t;
    end else if (o == 8'hE3) begin
      c = 16;
      t = {pm[sp + 16'd1], pm[sp]};
      wr(sp + 16'd1, r[4]);
      wr(sp, r[5]);
      {r[4], r[5]} = t;
    end else if (o == 8'hE9) begin
      c = 6;
      pc = hl;
    end else if (o[7:6] == 2'h3 && o[3:0] == 4'h5) begin
      c = 12;
      sp -= 16'd2;
      wr(sp + 16'd1, r[hx(o)]);
      wr(sp, r[hx(o) ^ 1]);
    end else if (o[7:6] == 2'h3 && o[3:0] == 4'h1) begin
      c = 10;
      {r[hx(o)], r[hx(o) ^ 1]} = {pm[sp + 16'd1], pm[sp]};
      sp += 16'd2;
    end else if (o[7:6] == 2'h3 && (o[2:1] == 2'h1 || o[2:0] == 3'h4 || o == 8'hCD)) begin
      tk = o[0] || (r[6][fb[o[5:4]]] == o[3]);
      c = o[2] ? (tk ? 18 : 9) : (tk ? 10 : 7);
      pc += 16'd2;
      if (tk && o[2]) begin
        sp -= 16'd2;
        wr(sp + 16'd1, pc[15:8]);
        wr(sp, pc[7:0]);
      end
      if (tk) pc = {hi, lo};
    end else u = 1'b1;
  endtask
  task automatic run(input bit wt);
    int c, n;
    logic u, first;
    pm = img;
    mem.m = img;
    mem.log_q.delete();
    wq.delete();
    r = '{default: 8'h00};
    pc = 16'h0000;
    sp = 16'h0000;
    first = 1'b1;
    rst = 1'b1;
    hold_req = 1'b0;
    wait_n = 2'h0;
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    while (pc != end_pc) begin
      step(c, u);
      n = 0;
      do begin
        @(posedge sys_clk);
        #1 n++;
        // Random waits and holds stretch some transfers, so only results are compared then.
        if (wt) begin
          wait_n = 2'($random(seed));
          hold_req = ($random(seed) & 7) == 0;
        end
      end while (done !== 1'b1 && n < 400);
      if (n >= 400) begin
        cmp(24'h00_0000, 24'h00_0001, "timeout");
        final_report();
      end
      cmp(pc_v, pc, "pc");
      cmp(sp_v, sp, "sp");
      cmp(unsup, u, "unsupported");
      cmp(24'(io_mem), 24'(cmsb_pkg::IO_MEM_MEMORY), "io_mem");
      if (!wt && !first) cmp(24'(n), 24'(c * DIV), "cycles");
      cmp(24'(mem.log_q.size()), 24'(wq.size()), "write count");
      while (mem.log_q.size() > 0 && wq.size() > 0) begin
        cmp(mem.log_q.pop_front(), wq.pop_front(), "write");
      end
      first = 1'b0;
    end
  endtask
  initial begin
    pa = 0;
    e(32'h0080_0031, 3);
    e(8'h01 | $random(seed) << 8, 3);
    e(8'h11 | $random(seed) << 8, 3);
    e(32'h0090_0021, 3);
    e(8'h36 | $random(seed) << 8, 2);
    for (int d = 0; d < 8; d++) begin
      if (d < 4 || d == 7) e(d * 8 + 6 | $random(seed) << 8, 2);
    end
    for (int o = 8'h40; o < 8'h80; o++) begin
      if (o[5:3] != 3'h4 && o[5:3] != 3'h5) e(o);
    end
    foreach (fx[i]) e(fx[i]);
    for (int i = 0; i < 16; i++) begin
      e(8'h01 | $random(seed) << 8, 3);
      e(16'hF1C5, 2);
      e(8'hC2 | (i % 8) << 3 | (pa + 4) << 8, 4);
      e(8'hC4 | (i % 8) << 3 | (pa + 4) << 8, 4);
    end
    e(8'hCD | (pa + 3) << 8, 3);
    e(8'hC3 | (pa + 3) << 8, 3);
    e(8'h21 | (pa + 4) << 8, 3);
    e(8'hE9);
    end_pc = pa[15:0];
    e(8'hC3 | pa << 8, 3);
    run(1'b0);
    run(1'b1);
    final_report();
  end
endmodule // cmsb_core_tb
bind cmsb_core cmsb_core_assertions #(.T_STATE_DIV(T_STATE_DIV)) u_chk (.sys_clk(sys_clk),
  .rst(rst), .ready(ready), .hold_req(hold_req), .bus_addr(bus_addr),
  .bus_addr_oe(bus_addr_oe), .bus_wdata(bus_wdata), .bus_data_oe(bus_data_oe),
  .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .io_mem_oe(io_mem_oe),
  .bus_grant_ack(bus_grant_ack), .instr_done(instr_done));
